/* File: logic/drc_cond_gen.v */
/*
  Condition generator: from a 40-bit result and its operation class,
  derives the negative, zero, overflow and greater flags and the DSP
  condition flag for the selected mode. Purely combinational.
  Assumes the caller registers the outputs.
*/
`timescale 1ns/1ps
`include "drc_regs.vh"

module drc_cond_gen (
  input wire [2:0] i_cs,
  input wire i_is_arith,
  input wire i_is_shift,
  input wire i_carry,
  input wire i_last_out,
  input wire i_msb_guard,
  input wire i_msb_word,
  input wire i_zero,
  input wire i_ovf,
  input wire i_guard_ovf,
  output reg o_neg,
  output reg o_zero,
  output reg o_ovf,
  output reg o_gt,
  output reg o_dc
);

  always @* begin
    o_neg = i_is_arith ? i_msb_guard : i_msb_word;
    o_zero = i_zero;
    o_ovf = i_is_arith & i_ovf;
    o_gt = i_is_arith & ~((i_msb_guard ^ i_guard_ovf) | i_zero);
    case (i_cs)
      `DRC_CS_CARRY: o_dc = i_is_shift ? i_last_out : (i_is_arith & i_carry);
      `DRC_CS_NEG: o_dc = i_is_arith ? i_msb_guard : i_msb_word;
      `DRC_CS_ZERO: o_dc = i_zero;
      `DRC_CS_OVF: o_dc = i_is_arith & i_ovf;
      `DRC_CS_GT: o_dc = i_is_arith & ~((i_msb_guard ^ i_guard_ovf) | i_zero);
      `DRC_CS_GE: o_dc = i_is_arith & ~(i_msb_guard ^ i_guard_ovf);
      default: o_dc = 1'b0;
    endcase
  end

endmodule // drc_cond_gen

/* File: logic/drc_regs.vh */
/*
  Constants for the DSP round and condition slice: register offsets,
  field positions, reset values, encodings and fixed values.
  Assumes inclusion by bare name from the slice's design files.
*/
`ifndef DRC_REGS_VH
`define DRC_REGS_VH

// Register offsets (byte addresses)
`define DRC_OFF_CTRL 4'h0
`define DRC_OFF_SRCX 4'h4
`define DRC_OFF_SRCY 4'h8
`define DRC_OFF_STAT 4'hC

// Control word fields
`define DRC_CTRL_CS_LO 0
`define DRC_CTRL_SAT 3
`define DRC_CTRL_GUARD 4
`define DRC_CTRL_COND 5
`define DRC_CTRL_RST 32'h0000_0000

// Status word fields
`define DRC_ST_DC 0
`define DRC_ST_N 1
`define DRC_ST_Z 2
`define DRC_ST_V 3
`define DRC_ST_GT 4

// Operation codes
`define DRC_OP_ROUND 3'h0
`define DRC_OP_ARITH 3'h1
`define DRC_OP_LOGIC 3'h2
`define DRC_OP_ASHIFT 3'h3
`define DRC_OP_LSHIFT 3'h4

// Condition select codes
`define DRC_CS_CARRY 3'h0
`define DRC_CS_NEG 3'h1
`define DRC_CS_ZERO 3'h2
`define DRC_CS_OVF 3'h3
`define DRC_CS_GT 3'h4
`define DRC_CS_GE 3'h5

// Rounding constant and limits
`define DRC_ROUND_ADD 40'h00_0000_8000
`define DRC_LOW_MASK 40'hFF_FFFF_0000
`define DRC_MAX32 40'h00_7FFF_FFFF
`define DRC_MIN32 40'hFF_8000_0000
`define DRC_MAX32_RND 40'h00_7FFF_0000

`endif

/* File: logic/drc_round_unit.v */
/*
  DSP round and condition slice with a classic Wishbone register port.
  Software loads the two operand registers and the control word; the
  pipeline issues operations on i_op_valid. Results and flags land in
  the final (DSP) stage, one clock after issue.
  Assumes a single 125 MHz clock and synchronous pipeline inputs.
*/
// Decided for this implementation: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "drc_regs.vh"

module drc_round_unit (
  input wire i_clk,
  input wire i_nrst,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [3:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  input wire i_op_valid,
  input wire [2:0] i_op_code,
  input wire i_op_cond,
  input wire i_op_use_y,
  input wire [2:0] i_op_sx,
  input wire [2:0] i_op_sy,
  input wire [2:0] i_op_dz,
  input wire [39:0] i_op_b,
  input wire i_op_carry,
  input wire i_op_last_out,
  output reg [39:0] o_result,
  output reg [2:0] o_result_dest,
  output reg o_result_valid,
  output reg o_dsp_condition_flag,
  output reg o_negative_flag,
  output reg o_zero_flag,
  output reg o_overflow_flag,
  output reg o_greater_flag
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release
  reg rst_meta;
  reg rst_sync;
  wire rst_n = rst_sync;

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Functions
  function [31:0] wb_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] sel;
    integer k;
    begin
      wb_merge = old_val;
      for (k = 0; k < 4; k = k + 1) begin
        if (sel[k]) begin
          wb_merge[k*8 +: 8] = new_val[k*8 +: 8];
        end
      end
    end
  endfunction

  // Sign-extend a 32-bit word into a 40-bit guarded word
  function [39:0] sext40;
    input [31:0] v;
    begin
      sext40 = {{8{v[31]}}, v};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Register file
  reg [31:0] ctrl;
  reg [39:0] srcx;
  reg [39:0] srcy;
  wire wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire [2:0] cs = ctrl[`DRC_CTRL_CS_LO +: 3];
  wire sat_en = ctrl[`DRC_CTRL_SAT];
  wire guard_en = ctrl[`DRC_CTRL_GUARD];
  wire cond_gate = ctrl[`DRC_CTRL_COND];

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `DRC_CTRL_RST;
      srcx <= 40'h00_0000_0000;
      srcy <= 40'h00_0000_0000;
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= wb_req;
      if (wb_req && i_wb_we) begin
        case (i_wb_adr)
          `DRC_OFF_CTRL: ctrl <= wb_merge(ctrl, i_wb_dat, i_wb_sel) & 32'h0000_003F;
          `DRC_OFF_SRCX: srcx <= sext40(wb_merge(srcx[31:0], i_wb_dat, i_wb_sel));
          `DRC_OFF_SRCY: srcy <= sext40(wb_merge(srcy[31:0], i_wb_dat, i_wb_sel));
          default: ;
        endcase
      end
      if (wb_req && !i_wb_we) begin
        case (i_wb_adr)
          `DRC_OFF_CTRL: o_wb_dat <= ctrl;
          `DRC_OFF_SRCX: o_wb_dat <= srcx[31:0];
          `DRC_OFF_SRCY: o_wb_dat <= srcy[31:0];
          `DRC_OFF_STAT: o_wb_dat <= {27'h0000000, o_greater_flag, o_overflow_flag,
                                      o_zero_flag, o_negative_flag, o_dsp_condition_flag};
          default: o_wb_dat <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Operand selection
  // x side: every code reads srcx; y side: codes 1,2,5,6 read srcy, codes 0,3,4,7 read srcx
  reg [39:0] src;
  always @* begin
    if (i_op_use_y) begin
      src = (i_op_sy[0] ^ i_op_sy[1]) ? srcy : srcx;
    end else begin
      src = srcx;
    end
    if (!guard_en) begin
      src = sext40(src[31:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Arithmetic
  wire is_round = (i_op_code == `DRC_OP_ROUND);
  wire is_arith = is_round | (i_op_code == `DRC_OP_ARITH) | (i_op_code == `DRC_OP_ASHIFT);
  wire is_shift = (i_op_code == `DRC_OP_ASHIFT) | (i_op_code == `DRC_OP_LSHIFT);
  wire [40:0] sum = {1'b0, src} + {1'b0, `DRC_ROUND_ADD};
  wire [39:0] rounded = sum[39:0] & `DRC_LOW_MASK;
  wire [39:0] raw = is_round ? rounded : i_op_b;
  wire rnd_carry = sum[40];
  // Overflow beyond 32-bit word, and beyond the full 40-bit range
  wire word_ovf = (raw[39:31] != {9{raw[39]}});
  wire guard_ovf = is_round & ~src[39] & raw[39];
  wire ovf_any = is_arith & word_ovf;

  reg [39:0] stored;
  reg ovf_flag;
  always @* begin
    stored = raw;
    ovf_flag = ovf_any;
    if (is_round && sat_en && (word_ovf || guard_ovf)) begin
      stored = (guard_ovf || !raw[39]) ? `DRC_MAX32_RND : `DRC_MIN32;
      ovf_flag = 1'b0;
    end
  end

  wire zero_res = (stored == 40'h00_0000_0000);

  wire c_neg;
  wire c_zero;
  wire c_ovf;
  wire c_gt;
  wire c_dc;

  drc_cond_gen u_cond (
    .i_cs(cs),
    .i_is_arith(is_arith),
    .i_is_shift(is_shift),
    .i_carry(is_round ? rnd_carry : i_op_carry),
    .i_last_out(i_op_last_out),
    .i_msb_guard(stored[39]),
    .i_msb_word(stored[31]),
    .i_zero(zero_res),
    .i_ovf(ovf_flag),
    .i_guard_ovf(guard_ovf & ~sat_en),
    .o_neg(c_neg),
    .o_zero(c_zero),
    .o_ovf(c_ovf),
    .o_gt(c_gt),
    .o_dc(c_dc)
  );

  ////////////////////////////////////////////////////////////////////////
  // DSP stage
  wire cond_inst = i_op_cond & ~is_round;
  wire takes_effect = ~cond_inst | ~cond_gate | o_dsp_condition_flag;
  wire flag_update = i_op_valid & ~cond_inst;

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_result <= 40'h00_0000_0000;
      o_result_dest <= 3'h0;
      o_result_valid <= 1'b0;
      o_dsp_condition_flag <= 1'b0;
      o_negative_flag <= 1'b0;
      o_zero_flag <= 1'b0;
      o_overflow_flag <= 1'b0;
      o_greater_flag <= 1'b0;
    end else begin
      o_result_valid <= i_op_valid & takes_effect;
      if (i_op_valid && takes_effect) begin
        o_result <= stored;
        o_result_dest <= i_op_dz;
      end
      if (flag_update) begin
        o_dsp_condition_flag <= c_dc;
        o_negative_flag <= c_neg;
        o_zero_flag <= c_zero;
        o_overflow_flag <= c_ovf;
        o_greater_flag <= c_gt;
      end
    end
  end

endmodule // drc_round_unit

/* File: sim/drc_pipe_model.sv */
/* Pipeline model: issues one DSP operation per call.
   Assumes the slice samples op fields on the rising edge. */
`timescale 1ns/1ps
module drc_pipe_model (
  input wire i_clk,
  output reg o_valid,
  output reg [2:0] o_code,
  output reg o_cond,
  output reg o_use_y,
  output reg [2:0] o_sy,
  output reg [2:0] o_dz,
  output reg [39:0] o_b,
  output reg o_carry,
  output reg o_last
);
  initial {o_valid, o_code, o_cond, o_use_y, o_sy, o_dz, o_b, o_carry, o_last} = 54'h0;
  // Fields stand for one sampling edge, then the operand bus is scrambled
  task issue(input [2:0] c, input cd, input uy, input [2:0] dz, input [39:0] b,
    input cy, input lo);
    begin
      @(posedge i_clk);
      {o_valid, o_code, o_cond, o_use_y, o_sy, o_dz, o_b, o_carry, o_last} <=
        {1'b1, c, cd, uy, uy ? 3'h2 : 3'h0, dz, b, cy, lo};
      @(posedge i_clk);
      {o_valid, o_b} <= {1'b0, ~b};
    end
  endtask
endmodule // drc_pipe_model

/* File: sim/drc_round_props.sv */
/* Checker for the round and condition slice.
   Assumes binding to drc_round_unit ports. */
`timescale 1ns/1ps
module drc_round_props (
  input wire i_clk,
  input wire i_nrst,
  input wire i_op_valid,
  input wire [2:0] i_op_code,
  input wire i_op_cond,
  input wire [2:0] i_op_dz,
  input wire [39:0] i_op_b,
  input wire [39:0] o_result,
  input wire [2:0] o_result_dest,
  input wire o_result_valid,
  input wire o_dsp_condition_flag,
  input wire o_negative_flag,
  input wire o_zero_flag,
  input wire o_overflow_flag,
  input wire o_greater_flag
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  wire rnd = i_op_valid && i_op_code == 3'h0;
  wire unc = i_op_valid && !i_op_cond && i_op_code != 3'h0;
  wire lgc = unc && (i_op_code == 3'h2 || i_op_code == 3'h4);
  wire ari = unc && (i_op_code == 3'h1 || i_op_code == 3'h3);
  wire nsrc = ari ? i_op_b[39] : i_op_b[31];
  wire [4:0] flg = {o_greater_flag, o_overflow_flag, o_zero_flag, o_negative_flag,
    o_dsp_condition_flag};
  a_round_low: assert property (
    rnd |=> o_result_valid && o_result[15:0] == 16'h0000) else $error("round low word");
  a_round_nz: assert property (
    rnd |=> o_negative_flag == o_result[39] && o_zero_flag == (o_result == 40'h0))
    else $error("round flags");
  a_round_gt: assert property (
    rnd |=> o_greater_flag == (!o_result[39] && o_result != 40'h0)) else $error("round gt");
  a_round_dest: assert property (
    rnd |=> o_result_dest == $past(i_op_dz)) else $error("round dest");
  a_pass_result: assert property (
    unc |=> o_result_valid && o_result == $past(i_op_b) && o_result_dest == $past(i_op_dz))
    else $error("op result");
  a_cond_hold: assert property (
    i_op_valid && i_op_cond && !rnd |=> $stable(flg)) else $error("cond flags moved");
  a_logic_clear: assert property (
    lgc |=> !o_overflow_flag && !o_greater_flag) else $error("logic flags");
  a_zero_set: assert property (
    unc |=> o_zero_flag == ($past(i_op_b) == 40'h0)) else $error("zero flag");
  a_neg_source: assert property (
    ari || lgc |=> o_negative_flag == $past(nsrc)) else $error("negative flag");
  c_round_ovf: cover property (rnd ##1 o_overflow_flag);
  c_cond_skip: cover property (i_op_valid && i_op_cond ##1 !o_result_valid);
  c_logic_dc: cover property (lgc ##1 o_dsp_condition_flag);
endmodule // drc_round_props
bind drc_round_unit drc_round_props props_u (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_op_valid(i_op_valid), .i_op_code(i_op_code), .i_op_cond(i_op_cond),
  .i_op_dz(i_op_dz), .i_op_b(i_op_b), .o_result(o_result), .o_result_dest(o_result_dest),
  .o_result_valid(o_result_valid), .o_dsp_condition_flag(o_dsp_condition_flag),
  .o_negative_flag(o_negative_flag), .o_zero_flag(o_zero_flag),
  .o_overflow_flag(o_overflow_flag), .o_greater_flag(o_greater_flag));

/* File: sim/dsp_round_and_condition_logic_test.sv */
/* Testbench: register access, rounding sweep, pass-through ops, gating.
   Assumes the slice, the pipeline model and the checker. */
`timescale 1ns/1ps
`include "drc_regs.vh"
module dsp_round_and_condition_logic_test;
  reg i_clk = 1'b0;
  reg i_nrst = 1'b0;
  reg cyc = 1'b0;
  reg stb = 1'b0;
  reg we = 1'b0;
  reg [3:0] adr = 4'h0;
  reg [31:0] wdat = 32'h0;
  wire [31:0] rdat;
  wire ack, v, cd, uy, cy, lo, rv, dc, n, z, ov, gt;
  wire [2:0] c, sy, dz, rdz;
  wire [39:0] b, res;
  integer error_cnt = 0;
  integer checked = 0;
  integer i, j, k;
  reg [31:0] rd, s;
  reg [39:0] r;
  reg [4:0] f;
  reg oc, vf;
  localparam [191:0] SRC = {32'h7FFF_8000, 32'hFFFF_FFFF, 32'h8000_0000, 32'h0000_7FFF,
    32'h1234_8000, 32'h7FFF_7FFF};
  localparam [159:0] BV = {40'h0, 40'hFF_8000_0000, 40'h00_8000_0000, 40'h1};
  initial forever #4 i_clk = ~i_clk;
  drc_round_unit dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_op_valid(v), .i_op_code(c), .i_op_cond(cd), .i_op_use_y(uy),
    .i_op_sx(3'h0), .i_op_sy(sy), .i_op_dz(dz), .i_op_b(b), .i_op_carry(cy),
    .i_op_last_out(lo), .o_result(res), .o_result_dest(rdz), .o_result_valid(rv),
    .o_dsp_condition_flag(dc), .o_negative_flag(n), .o_zero_flag(z),
    .o_overflow_flag(ov), .o_greater_flag(gt));
  drc_pipe_model pipe_u (.i_clk(i_clk), .o_valid(v), .o_code(c), .o_cond(cd), .o_use_y(uy),
    .o_sy(sy), .o_dz(dz), .o_b(b), .o_carry(cy), .o_last(lo));
  task report_and_stop;
    begin
      if (error_cnt == 0 && checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [39:0] e, input [39:0] got);
    begin
      checked = checked + 1;
      if (got !== e) begin
        error_cnt = error_cnt + 1;
        $display("Error %s expected %h seen %h", nm, e, got);
      end
    end
  endtask
  task wb(input w, input [3:0] a, input [31:0] d);
    integer t;
    begin
      @(posedge i_clk);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      t = 0;
      do begin
        @(posedge i_clk);
        t = t + 1;
      end while (ack !== 1'b1 && t < 20);
      rd = rdat;
      {cyc, stb} <= 2'b00;
      if (ack !== 1'b1) begin
        error_cnt = error_cnt + 1;
        $display("Error wb_ack expected 1 seen %b", ack);
        report_and_stop;
      end
    end
  endtask
  function vof(input [39:0] x);
    vof = !(&x[39:31] || ~|x[39:31]);
  endfunction
  function [4:0] fl(input [2:0] op, input [2:0] cs, input [39:0] x, input ci, input vi);
    reg a, nn, zz, vv, g, d;
    begin
      a = op == 3'h0 || op == 3'h1 || op == 3'h3;
      nn = a ? x[39] : x[31];
      zz = x == 40'h0;
      vv = a & vi;
      g = a & ~nn & ~zz;
      case (cs)
        3'h0: d = op != 3'h2 && ci;
        3'h1: d = nn;
        3'h2: d = zz;
        3'h3: d = vv;
        3'h4: d = g;
        3'h5: d = a & ~nn;
        default: d = 1'b0;
      endcase
      fl = {g, vv, zz, nn, d};
    end
  endfunction
  task chkop(input [39:0] er, input [4:0] ef, input [2:0] ed);
    begin
      #1;
      chk("valid", 40'h1, {39'h0, rv});
      chk("result", er, res);
      chk("dest", {37'h0, ed}, {37'h0, rdz});
      chk("flags", {35'h0, ef}, {35'h0, gt, ov, z, n, dc});
      wb(1'b0, 4'hC, 32'h0);
      chk("status", {35'h0, ef}, {35'h0, rd[4:0]});
    end
  endtask
  task cnd(input e);
    begin
      #1;
      f = {gt, ov, z, n, dc};
      pipe_u.issue(3'h1, 1'b1, 1'b0, 3'h2, 40'h0, 1'b1, 1'b1);
      #1;
      chk("cond_valid", {39'h0, e}, {39'h0, rv});
      chk("cond_flags", {35'h0, f}, {35'h0, gt, ov, z, n, dc});
    end
  endtask
  initial begin
    repeat (5) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_clk);
    wb(1'b1, 4'h0, 32'hFFFF_FFFF);
    wb(1'b0, 4'h0, 32'h0);
    chk("ctrl", 40'h3F, {8'h0, rd});
    wb(1'b0, 4'h2, 32'h0);
    chk("unmapped", 40'h0, {8'h0, rd});
    for (k = 0; k < 4; k = k + 1)
      for (j = 0; j < 8; j = j + 1) begin
        wb(1'b1, 4'h0, {27'h0, k[1:0], j[2:0]});
        for (i = 0; i < 6; i = i + 1) begin
          s = SRC[i*32 +: 32];
          wb(1'b1, i[0] ? 4'h8 : 4'h4, s);
          {oc, r} = {1'b0, {8{s[31]}}, s} + 41'h00_0000_8000;
          r[15:0] = 16'h0;
          vf = vof(r);
          if (k[0] && vf) begin
            r = r[39] ? `DRC_MIN32 : `DRC_MAX32_RND;
            vf = 1'b0;
          end
          pipe_u.issue(3'h0, i[1], i[0], i[2:0], 40'h0, 1'b0, 1'b0);
          chkop(r, fl(3'h0, j[2:0], r, oc, vf), i[2:0]);
        end
      end
    for (j = 0; j < 8; j = j + 1) begin
      wb(1'b1, 4'h0, {29'h0, j[2:0]});
      for (k = 1; k < 5; k = k + 1)
        for (i = 0; i < 4; i = i + 1) begin
          r = BV[i*40 +: 40];
          pipe_u.issue(k[2:0], 1'b0, 1'b0, i[2:0], r, i[0], ~i[0]);
          chkop(r, fl(k[2:0], j[2:0], r, k > 2 ? ~i[0] : i[0], vof(r)), i[2:0]);
        end
    end
    wb(1'b1, 4'h0, 32'h21);
    pipe_u.issue(3'h1, 1'b0, 1'b0, 3'h1, 40'hFF_8000_0000, 1'b0, 1'b0);
    cnd(1'b1);
    pipe_u.issue(3'h1, 1'b0, 1'b0, 3'h1, 40'h1, 1'b0, 1'b0);
    cnd(1'b0);
    wb(1'b1, 4'h0, 32'h1);
    cnd(1'b1);
    report_and_stop;
  end
endmodule // dsp_round_and_condition_logic_test
